// ### inc/css_pkg.sv
// Purpose: Shared constants for the configuration startup sequencer
// Assumes: Register port with one-cycle read latency, 8-bit word index
// Notes: Offsets are word indices on the plain register port
package css_pkg;
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PHASE = 8'h01;
   localparam logic [7:0] REG_CLKDIV = 8'h02;
   localparam logic [7:0] REG_SCRATCH = 8'h03;
   localparam logic [7:0] REG_FALLBACK_LO = 8'h04;
   localparam logic [7:0] REG_FALLBACK_HI = 8'h05;
   localparam logic [7:0] REG_STATUS = 8'h06;
   // Control bit positions
   localparam int CTRL_DRIVE = 0;
   localparam int CTRL_PORGATE = 1;
   localparam int CTRL_RESTORE = 2;
   localparam int CTRL_ENCRYPT = 3;
   localparam int CTRL_KEYSEL = 4;
   localparam int CTRL_EXTCLK = 5;
   localparam int CTRL_LUTMASK = 6;
   localparam int CTRL_PORTSEL = 7;
   localparam int CTRL_ERRSIG = 8;
   localparam int CTRL_DONE_PIPELINING = 9;
   localparam int CTRL_START = 10;
   localparam int CTRL_DIVMODE = 11;
   // Control reset: gating on, lut mask on, error signalling on
   localparam logic [15:0] CTRL_RESET = 16'h0142;
   // Phase field encodings: 1..6 phase, 7 done-tracking, 0 keep
   localparam logic [2:0] PH_KEEP = 3'h0;
   localparam logic [2:0] PH_DONE = 3'h7;
   localparam logic [2:0] PH_LAST = 3'h6;
   localparam logic [2:0] TRI_RESET = 3'h5;
   localparam logic [2:0] WE_RESET = 3'h6;
   localparam logic [2:0] CPL_RESET = 3'h4;
   // Phase register field positions
   localparam int PH_TRI_LSB = 0;
   localparam int PH_WE_LSB = 4;
   localparam int PH_CPL_LSB = 8;
   // Divider
   localparam logic [9:0] DIV_MAX = 10'h3fe;
   localparam logic [9:0] DIV_RESET = 10'h001;
   localparam logic [1:0] FIX_DIV1 = 2'h0;
   localparam logic [15:0] SCRATCH_RESET = 16'h0000;
   localparam logic [31:0] FALLBACK_RESET = 32'h0000_0000;
   typedef enum logic [3:0] {
      CSS_IDLE = 4'b0001,
      CSS_RUN = 4'b0010,
      CSS_WAIT = 4'b0100,
      CSS_FIN = 4'b1000
   } css_state_type;
endpackage

// ### rtl/css_sequencer.sv
// Purpose: Startup phase sequencer, suspend reset gating, clock divider, config bits
// Assumes: Single clock, synchronous active-low reset, pins pass two flops
// Notes: Phase strobe comes from the master clock divider enable
//
// Behaviour
// - Drive done pin high when enabled
// - Default gating keeps undervoltage reset always active
// - Gating off: detect only while suspend low
// - Restore flops from memory on wake
// - Key from battery storage or fuses
// - External clock pin used, fixed dividers
// - Separate divider: one or even to 1022
// - Sixteen-bit failsafe scratch, reset zero
// - Thirty-two-bit fallback address, two registers
// - Mask LUT memory frames from readback
// - Release tristate in phase one to six
// - Done-tracking tristate release on done input
// - Assert write enable in chosen phase
// - Block memories blocked until write enable
// - Done-tracking write enable; keep holds value
// - Encryption needs cipher and authentication keys
// - Internal port top or bottom select
// - Error pulls init pin low unless disabled
// - Signal completion in chosen phase
// - Done pipelining waits one edge more
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module css_sequencer #(
   parameter int DIV_W = 10
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic user_config_clock_pin,
   input wire logic done_pin_in,
   output logic done_pin_out,
   output logic done_pin_oe,
   output logic init_pin_out,
   output logic init_pin_oe,
   input wire logic suspend_pin,
   input wire logic undervoltage,
   input wire logic config_error,
   input wire logic wake_event,
   input wire logic cipher_key_ok,
   input wire logic authentication_key_ok,
   output logic global_tristate,
   output logic global_write_enable,
   output logic bram_enable,
   output logic config_complete,
   output logic por_reset,
   output logic flop_restore,
   output logic key_source_select,
   output logic image_accept,
   output logic lut_readback_mask,
   output logic config_port_bottom,
   output logic master_clock_tick,
   output logic [15:0] failsafe_user_scratch,
   output logic [31:0] fallback_image_address_regs
);
   // Configuration registers
   logic [15:0] ctrl;
   logic [11:0] phase_sel;
   logic [9:0] external_master_clock_divider;
   logic [1:0] fix_div;
   // Pin synchronisers
   logic [1:0] ucclk_s, done_s, susp_s, uv_s, err_s, wake_s;
   logic ucclk_prev;
   logic ucclk_rise;
   logic [DIV_W-1:0] div_cnt;
   logic [3:0] fix_cnt;
   // Sequencer state
   css_pkg::css_state_type state;
   logic [2:0] phase;
   logic done_pipe_d;
   logic done_input_signal;
   logic err_flag;
   logic wake_prev;
   logic [2:0] tri_ph, we_ph, cpl_ph;

   assign tri_ph = phase_sel[css_pkg::PH_TRI_LSB +: 3];
   assign we_ph = phase_sel[css_pkg::PH_WE_LSB +: 3];
   assign cpl_ph = phase_sel[css_pkg::PH_CPL_LSB +: 3];

   // Two-flop synchronisers for all pins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ucclk_s <= 2'h0;
         done_s <= 2'h0;
         susp_s <= 2'h0;
         uv_s <= 2'h0;
         err_s <= 2'h0;
         wake_s <= 2'h0;
      end else begin
         ucclk_s <= {ucclk_s[0], user_config_clock_pin};
         done_s <= {done_s[0], done_pin_in};
         susp_s <= {susp_s[0], suspend_pin};
         uv_s <= {uv_s[0], undervoltage};
         err_s <= {err_s[0], config_error};
         wake_s <= {wake_s[0], suspend_pin};
      end
   end

   // Register writes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl <= css_pkg::CTRL_RESET;
         phase_sel <= {1'b0, css_pkg::CPL_RESET, 1'b0, css_pkg::WE_RESET,
                       1'b0, css_pkg::TRI_RESET};
         external_master_clock_divider <= css_pkg::DIV_RESET;
         fix_div <= css_pkg::FIX_DIV1;
         failsafe_user_scratch <= css_pkg::SCRATCH_RESET;
         fallback_image_address_regs <= css_pkg::FALLBACK_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            css_pkg::REG_CTRL: begin
               ctrl <= reg_wdata[15:0];
            end
            css_pkg::REG_PHASE: begin
               phase_sel <= reg_wdata[11:0];
            end
            css_pkg::REG_CLKDIV: begin
               // Accept 1 or even values up to the maximum only
               if (reg_wdata[9:0] == css_pkg::DIV_RESET ||
                   (reg_wdata[0] == 1'b0 && reg_wdata[9:0] != 10'h000 &&
                    reg_wdata[9:0] <= css_pkg::DIV_MAX)) begin
                  external_master_clock_divider <= reg_wdata[9:0];
               end
               fix_div <= reg_wdata[17:16];
            end
            css_pkg::REG_SCRATCH: begin
               failsafe_user_scratch <= reg_wdata[15:0];
            end
            css_pkg::REG_FALLBACK_LO: begin
               fallback_image_address_regs[15:0] <= reg_wdata[15:0];
            end
            css_pkg::REG_FALLBACK_HI: begin
               fallback_image_address_regs[31:16] <= reg_wdata[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Register reads, one cycle latency, unmapped reads zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            css_pkg::REG_CTRL: reg_rdata <= {16'h0000, ctrl};
            css_pkg::REG_PHASE: reg_rdata <= {20'h00000, phase_sel};
            css_pkg::REG_CLKDIV: reg_rdata <= {14'h0000, fix_div, 6'h00,
                                               external_master_clock_divider};
            css_pkg::REG_SCRATCH: reg_rdata <= {16'h0000, failsafe_user_scratch};
            css_pkg::REG_FALLBACK_LO: reg_rdata <= {16'h0000,
                                                    fallback_image_address_regs[15:0]};
            css_pkg::REG_FALLBACK_HI: reg_rdata <= {16'h0000,
                                                    fallback_image_address_regs[31:16]};
            css_pkg::REG_STATUS: reg_rdata <= {21'h000000, err_flag, done_input_signal,
                                               state, phase, global_write_enable,
                                               global_tristate};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // Master clock tick: external pin edge divided, else every clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ucclk_prev <= 1'b0;
         div_cnt <= '0;
         fix_cnt <= 4'h0;
         master_clock_tick <= 1'b0;
      end else begin
         ucclk_prev <= ucclk_s[1];
         master_clock_tick <= 1'b0;
         if (!ctrl[css_pkg::CTRL_EXTCLK]) begin
            master_clock_tick <= 1'b1;
         end else if (ucclk_rise) begin
            if (ctrl[css_pkg::CTRL_DIVMODE]) begin
               // Fixed divide by 8, 4, 2 or 1
               if (fix_cnt >= (4'h1 << (3'h3 - {1'b0, fix_div})) - 4'h1) begin
                  fix_cnt <= 4'h0;
                  master_clock_tick <= 1'b1;
               end else begin
                  fix_cnt <= fix_cnt + 4'h1;
               end
            end else if (div_cnt >= DIV_W'(external_master_clock_divider) - 1'b1) begin
               div_cnt <= '0;
               master_clock_tick <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 1'b1;
            end
         end
      end
   end
   assign ucclk_rise = ucclk_s[1] & ~ucclk_prev;

   // Done input: pin value, or one tick later with pipelining
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_pipe_d <= 1'b0;
      end else if (master_clock_tick) begin
         done_pipe_d <= done_s[1];
      end
   end
   assign done_input_signal = ctrl[css_pkg::CTRL_DONE_PIPELINING] ? done_pipe_d : done_s[1];

   // Phase sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= css_pkg::CSS_IDLE;
         phase <= 3'h0;
      end else if (master_clock_tick) begin
         case (state)
            // Wait for start with no error pending
            css_pkg::CSS_IDLE: begin
               if (ctrl[css_pkg::CTRL_START] && !err_flag) begin
                  state <= css_pkg::CSS_RUN;
                  phase <= 3'h1;
               end
            end
            // Step through the numbered phases
            css_pkg::CSS_RUN: begin
               if (phase == css_pkg::PH_LAST) begin
                  state <= css_pkg::CSS_WAIT;
               end else begin
                  phase <= phase + 3'h1;
               end
            end
            // Hold until the done input goes high
            css_pkg::CSS_WAIT: begin
               if (done_input_signal) begin
                  state <= css_pkg::CSS_FIN;
               end
            end
            // Finished; clearing start rearms
            css_pkg::CSS_FIN: begin
               if (!ctrl[css_pkg::CTRL_START]) begin
                  state <= css_pkg::CSS_IDLE;
                  phase <= 3'h0;
               end
            end
            default: begin
               state <= css_pkg::CSS_IDLE;
            end
         endcase
      end
   end

   // Startup events, evaluated per phase
   always_ff @(posedge clk) begin
      if (!nrst) begin
         global_tristate <= 1'b1;
         global_write_enable <= 1'b0;
         config_complete <= 1'b0;
      end else if (master_clock_tick && state != css_pkg::CSS_IDLE) begin
         // Tristate release: done-tracked or phase-matched
         if (tri_ph == css_pkg::PH_DONE) begin
            if (done_input_signal) global_tristate <= 1'b0;
         end else if (tri_ph != css_pkg::PH_KEEP && state == css_pkg::CSS_RUN &&
                      phase == tri_ph) begin
            global_tristate <= 1'b0;
         end
         // Write enable chosen the same way
         if (we_ph == css_pkg::PH_DONE) begin
            if (done_input_signal) global_write_enable <= 1'b1;
         end else if (we_ph != css_pkg::PH_KEEP && state == css_pkg::CSS_RUN &&
                      phase == we_ph) begin
            global_write_enable <= 1'b1;
         end
         // Completion only on a numbered phase
         if (cpl_ph != css_pkg::PH_KEEP && cpl_ph != css_pkg::PH_DONE &&
             state == css_pkg::CSS_RUN && phase == cpl_ph) begin
            config_complete <= 1'b1;
         end
      end
   end
   assign bram_enable = global_write_enable;

   // Done pin: driven high actively when selected and config_complete is set, else released
   assign done_pin_out = 1'b1;
   assign done_pin_oe = ctrl[css_pkg::CTRL_DRIVE] & config_complete;

   // Sticky error flag, init pin pulled low
   always_ff @(posedge clk) begin
      if (!nrst) begin
         err_flag <= 1'b0;
      end else if (err_s[1]) begin
         err_flag <= 1'b1;
      end
   end
   assign init_pin_out = 1'b0;
   assign init_pin_oe = err_flag & ctrl[css_pkg::CTRL_ERRSIG];

   // Undervoltage reset gating and wake restore
   always_ff @(posedge clk) begin
      if (!nrst) begin
         por_reset <= 1'b0;
         wake_prev <= 1'b0;
         flop_restore <= 1'b0;
      end else begin
         if (ctrl[css_pkg::CTRL_PORGATE]) begin
            por_reset <= uv_s[1];
         end else begin
            por_reset <= uv_s[1] & ~susp_s[1];
         end
         wake_prev <= wake_s[1];
         flop_restore <= ctrl[css_pkg::CTRL_RESTORE] & wake_prev & ~wake_s[1];
      end
   end

   // Security and routing selects
   assign key_source_select = ctrl[css_pkg::CTRL_ENCRYPT] & ctrl[css_pkg::CTRL_KEYSEL];
   assign image_accept = ~ctrl[css_pkg::CTRL_ENCRYPT] |
                         (cipher_key_ok & authentication_key_ok);
   assign lut_readback_mask = ctrl[css_pkg::CTRL_LUTMASK];
   assign config_port_bottom = ctrl[css_pkg::CTRL_PORTSEL];

   // Unused wake input kept observed through suspend pin edge
   logic unused_wake;
   assign unused_wake = wake_event;

   // Checks
   // Keep setting leaves the tristate alone
   a_tri_keep: assert property (@(posedge clk) disable iff (!nrst)
      (tri_ph == css_pkg::PH_KEEP && $stable(tri_ph)) |=> $stable(global_tristate))
      else $error("tristate changed under keep");
   // Block memories open only on a startup tick
   a_bram_gate: assert property (@(posedge clk) disable iff (!nrst)
      $rose(bram_enable) |-> $past(master_clock_tick) && $past(state) != css_pkg::CSS_IDLE)
      else $error("block memory enabled outside startup");
   // A synced error pulls the init line next cycle
   a_init_low: assert property (@(posedge clk) disable iff (!nrst)
      (err_s[1] && ctrl[css_pkg::CTRL_ERRSIG]) |=> init_pin_oe)
      else $error("init pin not pulled");
   // Gating on: every undervoltage resets
   a_por_gate: assert property (@(posedge clk) disable iff (!nrst)
      (ctrl[css_pkg::CTRL_PORGATE] && uv_s[1]) |=> por_reset)
      else $error("undervoltage reset missed");
   // Gating off: suspend masks undervoltage
   a_por_susp: assert property (@(posedge clk) disable iff (!nrst)
      (!ctrl[css_pkg::CTRL_PORGATE] && susp_s[1]) |=> !por_reset)
      else $error("reset not gated in suspend");
   // Write enable follows its chosen phase
   a_we_phase: assert property (@(posedge clk) disable iff (!nrst)
      (master_clock_tick && state == css_pkg::CSS_RUN && phase == we_ph &&
       we_ph != css_pkg::PH_KEEP) |=> global_write_enable)
      else $error("write enable late");
   // No drive on the done pin unless selected
   a_done_drive: assert property (@(posedge clk) disable iff (!nrst)
      !ctrl[css_pkg::CTRL_DRIVE] |-> !done_pin_oe) else $error("done driven");
   // Phases step by one per tick
   a_phase_step: assert property (@(posedge clk) disable iff (!nrst)
      (master_clock_tick && state == css_pkg::CSS_RUN && phase < css_pkg::PH_LAST)
      |=> phase == $past(phase) + 3'h1) else $error("phase skipped");
endmodule
`default_nettype wire

// ### testbench/css_host_model.sv
// Purpose: Host side of the configuration pins for the startup bench
// Assumes: Done and init pins are open lines with pullups
// Notes: The host may hold done low on command to stall the device
`timescale 1ns/100ps
`default_nettype none
module css_host_model (
   input wire logic clk,
   input wire logic done_pin_out,
   input wire logic done_pin_oe,
   input wire logic init_pin_out,
   input wire logic init_pin_oe,
   input wire logic hold_done_low,
   input wire logic user_clock_run,
   output logic done_pin_in,
   output logic init_level,
   output logic user_config_clock_pin
);
   logic [1:0] half_cnt = 2'h0; // Clk cycles within a half period
   logic pin_q = 1'b0; // Master clock level
   // Done line: host pulldown wins, then device drive, then pullup
   always_comb begin
      if (hold_done_low) begin
         done_pin_in = 1'b0;
      end else if (done_pin_oe) begin
         done_pin_in = done_pin_out;
      end else begin
         done_pin_in = 1'b1;
      end
   end
   // Init line stays pulled up unless the device pulls it low
   assign init_level = init_pin_oe ? init_pin_out : 1'b1;
   assign user_config_clock_pin = pin_q;
   // Master clock, eight clk cycles a period, still while stopped
   always @(posedge clk) begin
      if (!user_clock_run) begin
         half_cnt <= 2'h0;
         pin_q <= 1'b0;
      end else begin
         half_cnt <= half_cnt + 2'h1;
         if (half_cnt == 2'h3) begin
            pin_q <= ~pin_q;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/config_startup_sequencer_test.sv
// Purpose: Self-checking bench for the startup sequencer
// Assumes: Host model on the pins, registers over the plain port
// Notes: A cycle ceiling cuts a hang short
`timescale 1ns/100ps
`default_nettype none
module config_startup_sequencer_test;
   // Inputs, all valued at time zero
   logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic suspend_pin = 1'b0, undervoltage = 1'b0, config_error = 1'b0;
   logic cipher_key_ok = 1'b0, authentication_key_ok = 1'b0;
   logic hold_done_low = 1'b0, user_clock_run = 1'b0;
   // Outputs and pin levels
   logic [31:0] reg_rdata, fallback_image_address_regs;
   logic [15:0] failsafe_user_scratch;
   logic user_config_clock_pin, done_pin_in, done_pin_out, done_pin_oe;
   logic init_pin_out, init_pin_oe, init_level, global_tristate, global_write_enable;
   logic bram_enable, config_complete, por_reset, flop_restore, key_source_select;
   logic image_accept, lut_readback_mask, config_port_bottom, master_clock_tick;
   int failures = 0, total_checks = 0, cyc = 0;
   int lat_a, lat_b, lat_c;
   localparam logic [31:0] ctrl0 = 32'h0000_0142; // Control after reset
   localparam int limit = 40000;
   css_sequencer dut_u (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .user_config_clock_pin, .done_pin_in, .done_pin_out, .done_pin_oe, .init_pin_out,
      .init_pin_oe, .suspend_pin, .undervoltage, .config_error, .wake_event(1'b0),
      .cipher_key_ok, .authentication_key_ok, .global_tristate, .global_write_enable,
      .bram_enable, .config_complete, .por_reset, .flop_restore, .key_source_select,
      .image_accept, .lut_readback_mask, .config_port_bottom, .master_clock_tick,
      .failsafe_user_scratch, .fallback_image_address_regs);
   css_host_model host_u (.clk, .done_pin_out, .done_pin_oe, .init_pin_out, .init_pin_oe,
      .hold_done_low, .user_clock_run, .done_pin_in, .init_level, .user_config_clock_pin);
   // Clock of 4 ns
   always #2 clk = ~clk;
   // Cycle ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == limit) begin
         failures++;
         results();
      end
   end
   // Closing report
   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Compare of register words
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Compare of single flags
   task automatic check_bit(input logic got, input logic exp);
      check_val({31'h0, got}, {31'h0, exp});
   endtask
   // Compare of cycle counts
   task automatic check_cnt(input int got, input int exp);
      check_val(got, exp);
   endtask
   // Reset held for 8 cycles
   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
   endtask
   // One write cycle
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // One read cycle, data taken in the following cycle
   task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      check_val(reg_rdata, exp);
   endtask
   // Reset values, unmapped place, scratch and fallback words
   task automatic test_regs();
      logic [7:0] ad [7];
      logic [31:0] rv [7];
      ad = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
      rv = '{ctrl0, 32'h0000_0465, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
      foreach (ad[i]) check_reg(ad[i], rv[i]);
      reg_write(8'h07, 32'hffff_ffff);
      check_reg(8'h07, 32'h0);
      reg_write(css_pkg::REG_SCRATCH, 32'hffff_a5c3);
      reg_write(css_pkg::REG_FALLBACK_LO, 32'h0000_5678);
      reg_write(css_pkg::REG_FALLBACK_HI, 32'h0000_1234);
      check_reg(css_pkg::REG_SCRATCH, 32'h0000_a5c3);
      check_val({16'h0, failsafe_user_scratch}, 32'h0000_a5c3);
      check_val(fallback_image_address_regs, 32'h1234_5678);
   endtask
   // Divider takes one or even values up to 1022 only
   task automatic test_divider();
      logic [31:0] dv [4];
      logic [31:0] ex [4];
      dv = '{32'h3, 32'h0, 32'h3ff, 32'h3fe};
      ex = '{32'h1, 32'h1, 32'h1, 32'h3fe};
      foreach (dv[i]) begin
         reg_write(css_pkg::REG_CLKDIV, dv[i]);
         check_reg(css_pkg::REG_CLKDIV, ex[i]);
      end
   endtask
   // Cycles up to the next tick, bounded
   task automatic next_tick(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (master_clock_tick !== 1'b1 && n < 1100);
   endtask
   // Spacing of ticks once the new setting has settled
   task automatic tick_gap(input logic [31:0] ctrl, input logic [31:0] div, output int n);
      reg_write(css_pkg::REG_CLKDIV, div);
      reg_write(css_pkg::REG_CTRL, ctrl);
      next_tick(n);
      next_tick(n);
      next_tick(n);
   endtask
   // Master clock source and every divider mode
   task automatic test_ticks();
      int n;
      @(posedge clk);
      user_clock_run <= 1'b1;
      tick_gap(ctrl0, 32'h1, n);
      check_cnt(n, 1);
      tick_gap(ctrl0 | 32'h20, 32'h1, n);
      check_cnt(n, 8);
      tick_gap(ctrl0 | 32'h20, 32'h2, n);
      check_cnt(n, 16);
      tick_gap(ctrl0 | 32'h20, 32'h6, n);
      check_cnt(n, 48);
      for (int f = 0; f < 4; f++) begin
         tick_gap(ctrl0 | 32'h820, {14'h0, f[1:0], 16'h0001}, n);
         check_cnt(n, 8 << (3 - f));
      end
      reg_write(css_pkg::REG_CTRL, ctrl0);
      @(posedge clk);
      user_clock_run <= 1'b0;
   endtask
   // Key source, mask, port select and image acceptance
   task automatic test_bits();
      logic [31:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 32'h0000_010a;
         c[4] = i[0];
         c[6] = ~i[0];
         c[7] = i[1];
         @(posedge clk);
         cipher_key_ok <= i[0];
         authentication_key_ok <= i[1];
         reg_write(css_pkg::REG_CTRL, c);
         @(negedge clk);
         check_bit(key_source_select, i[0]);
         check_bit(lut_readback_mask, ~i[0]);
         check_bit(config_port_bottom, i[1]);
         check_bit(image_accept, i[0] & i[1]);
      end
   endtask
   // Undervoltage reset with and without suspend gating
   task automatic test_por();
      for (int i = 0; i < 8; i++) begin
         reg_write(css_pkg::REG_CTRL, i[2] ? ctrl0 : ctrl0 & 32'hffff_fffd);
         suspend_pin <= i[0];
         undervoltage <= i[1];
         repeat (6) @(negedge clk);
         check_bit(por_reset, i[1] & (i[2] | ~i[0]));
      end
      @(posedge clk);
      suspend_pin <= 1'b0;
      undervoltage <= 1'b0;
   endtask
   // One restore pulse on wake only when enabled
   task automatic test_restore();
      int n;
      for (int r = 0; r < 2; r++) begin
         reg_write(css_pkg::REG_CTRL, ctrl0 | {29'h0, r[0], 2'h0});
         suspend_pin <= 1'b1;
         repeat (6) @(posedge clk);
         suspend_pin <= 1'b0;
         n = 0;
         repeat (12) begin
            @(negedge clk);
            n += int'(flop_restore === 1'b1);
         end
         check_cnt(n, r);
      end
   endtask
   // Run from reset, stamping complete, release and write enable
   task automatic run_seq(input logic [31:0] ctrl, input logic [31:0] ph,
         output int c, output int t, output int w);
      int n;
      do_reset();
      reg_write(css_pkg::REG_PHASE, ph);
      reg_write(css_pkg::REG_CTRL, ctrl | 32'h400);
      c = -1;
      t = -1;
      w = -1;
      n = 0;
      while (n < 40 && (c < 0 || t < 0 || w < 0)) begin
         @(negedge clk);
         n++;
         if (config_complete === 1'b1 && c < 0) c = n;
         if (global_tristate === 1'b0 && t < 0) t = n;
         if (global_write_enable === 1'b1 && w < 0) w = n;
         check_bit(bram_enable, w >= 0);
      end
   endtask
   // Default and boundary phase plans, with and without active done drive
   task automatic test_sequence();
      int c, t, w;
      run_seq(ctrl0, 32'h0000_0465, c, t, w);
      check_cnt(t - c, 1);
      check_cnt(w - t, 1);
      check_bit(done_pin_oe, 1'b0);
      run_seq(ctrl0 | 32'h1, 32'h0000_0312, c, t, w);
      check_cnt(t - w, 1);
      check_cnt(c - t, 1);
      check_bit(done_pin_oe & done_pin_out, 1'b1);
   endtask
   // Done tracking and keep while the host holds done low
   task automatic run_track(input logic [31:0] ctrl, input logic [31:0] ph,
         input logic tri_end, input logic we_end, output int lat);
      @(posedge clk);
      hold_done_low <= 1'b1;
      do_reset();
      reg_write(css_pkg::REG_PHASE, ph);
      reg_write(css_pkg::REG_CTRL, ctrl | 32'h400);
      repeat (30) @(negedge clk);
      check_bit(global_tristate, 1'b1);
      check_bit(global_write_enable, 1'b0);
      @(posedge clk);
      hold_done_low <= 1'b0;
      lat = 0;
      while (lat < 20 && global_tristate === 1'b1 && global_write_enable === 1'b0) begin
         @(negedge clk);
         lat++;
      end
      repeat (10) @(negedge clk);
      check_bit(global_tristate, tri_end);
      check_bit(global_write_enable, we_end);
      check_bit(bram_enable, we_end);
   endtask
   // Error signalling off, then on, then cleared by reset
   task automatic test_error();
      reg_write(css_pkg::REG_CTRL, ctrl0 & 32'hffff_feff);
      config_error <= 1'b1;
      repeat (6) @(negedge clk);
      check_bit(init_level, 1'b1);
      reg_write(css_pkg::REG_CTRL, ctrl0);
      repeat (3) @(negedge clk);
      check_bit(init_level, 1'b0);
      @(posedge clk);
      config_error <= 1'b0;
      do_reset();
      repeat (4) @(negedge clk);
      check_bit(init_level, 1'b1);
      check_reg(css_pkg::REG_STATUS, 32'h0000_0221);
   endtask
   // Main sequence
   initial begin
      do_reset();
      test_regs();
      test_divider();
      test_ticks();
      test_bits();
      test_por();
      test_restore();
      test_sequence();
      run_track(ctrl0, 32'h0000_0607, 1'b0, 1'b0, lat_a);
      run_track(ctrl0 | 32'h200, 32'h0000_0607, 1'b0, 1'b0, lat_b);
      run_track(ctrl0, 32'h0000_0670, 1'b1, 1'b1, lat_c);
      check_cnt(lat_b - lat_a, 1);
      check_cnt(lat_c, lat_a);
      test_error();
      results();
   end
endmodule
`default_nettype wire
